// ===== cfg_pkg.sv
// constants for the synthesizer, calibration, amplifier and matching register group
// assumes a register port with byte-wide data and a 100 MHz system clock
package cfg_pkg;

    // register offsets (byte addresses on the plain port)
    localparam logic [7:0] OFS_LOOP_GAIN   = 8'h1A;
    localparam logic [7:0] OFS_CAL_CTRL    = 8'h1B;
    localparam logic [7:0] OFS_AMP_LEVEL   = 8'h1C;
    localparam logic [7:0] OFS_MATCH_CAPS  = 8'h1D;
    localparam logic [7:0] OFS_PHASE_TRIM  = 8'h1E;
    // status register for the calibration sequencer
    localparam logic [7:0] OFS_CAL_STATUS  = 8'h3F;

    // calibration control field positions
    localparam int CAL_TRIG_BIT  = 7;
    localparam int CAL_BOTH_BIT  = 6;
    localparam int CAL_WAIT_HI   = 5;
    localparam int CAL_WAIT_LO   = 4;
    localparam int CAL_SEED_HI   = 2;
    localparam int CAL_SEED_LO   = 0;

    // reset values
    localparam logic [7:0] RST_LOOP_GAIN  = 8'h86;
    localparam logic [7:0] RST_CAL_CTRL   = 8'h05;
    localparam logic [7:0] RST_AMP_LEVEL  = 8'h0F;
    localparam logic [7:0] RST_MATCH_CAPS = 8'h00;
    localparam logic [7:0] RST_PHASE_TRIM = 8'h00;

    // writable bits of the calibration control register (bit 3 reserved)
    localparam logic [7:0] CAL_CTRL_MASK  = 8'hF7;

    // calibration wait times in reference-clock periods
    localparam int CAL_WAIT_0 = 90000;
    localparam int CAL_WAIT_1 = 110000;
    localparam int CAL_WAIT_2 = 130000;
    localparam int CAL_WAIT_3 = 200000;

    // calibration sequencer states
    typedef enum logic [1:0] {
        CAL_IDLE,
        CAL_RUN,
        CAL_STORE
    } cal_state_t;

endpackage : cfg_pkg

// ===== cal_sequencer.sv
// calibration sequencer: waits the selected number of reference periods,
// then raises store strobes for frequency setting A and/or B
// assumes ref_tick is a one-cycle pulse per reference-clock period
`timescale 1ns/10ps
`default_nettype none
module cal_sequencer #(
    parameter int WAIT0 = cfg_pkg::CAL_WAIT_0,
    parameter int WAIT1 = cfg_pkg::CAL_WAIT_1,
    parameter int WAIT2 = cfg_pkg::CAL_WAIT_2,
    parameter int WAIT3 = cfg_pkg::CAL_WAIT_3
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_b,
    // control
    input  wire logic       start,      // one-cycle start pulse
    input  wire logic       ref_tick,   // reference period tick
    input  wire logic [1:0] wait_sel,   // duration code
    input  wire logic       store_both, // write A and B
    input  wire logic       freq_sel,   // 0 selects A, 1 selects B
    // status and results
    output logic            busy,
    output logic            store_a,
    output logic            store_b
);

    // wait length lookup for a duration code
    function automatic logic [17:0] wait_len(input logic [1:0] code);
        unique case (code)
            2'h0: wait_len = 18'(WAIT0);
            2'h1: wait_len = 18'(WAIT1);
            2'h2: wait_len = 18'(WAIT2);
            2'h3: wait_len = 18'(WAIT3);
        endcase
    endfunction : wait_len

    cfg_pkg::cal_state_t state_q;   // sequencer state
    logic [17:0]         count_q;   // reference periods left
    logic                both_q;    // latched dual-store option
    logic                fsel_q;    // latched frequency select

    ////////////////////////////////////////////////////////////////////////
    // state and countdown
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= cfg_pkg::CAL_IDLE;
            count_q <= 18'h00000;
            both_q  <= 1'b0;
            fsel_q  <= 1'b0;
        end else begin
            unique case (state_q)
                cfg_pkg::CAL_IDLE: begin
                    // options latched at start so mid-run writes do not split a result
                    if (start) begin
                        state_q <= cfg_pkg::CAL_RUN;
                        count_q <= wait_len(wait_sel);
                        both_q  <= store_both;
                        fsel_q  <= freq_sel;
                    end
                end
                cfg_pkg::CAL_RUN: begin
                    // hold until the selected period count is spent
                    if (ref_tick) begin
                        if (count_q <= 18'h00001) begin
                            state_q <= cfg_pkg::CAL_STORE;
                        end
                        count_q <= count_q - 18'h00001;
                    end
                end
                cfg_pkg::CAL_STORE: begin
                    state_q <= cfg_pkg::CAL_IDLE;
                end
                default: state_q <= cfg_pkg::CAL_IDLE;
            endcase
        end
    end

    // result store strobes
    assign busy    = (state_q != cfg_pkg::CAL_IDLE);
    assign store_a = (state_q == cfg_pkg::CAL_STORE) && (both_q || !fsel_q);
    assign store_b = (state_q == cfg_pkg::CAL_STORE) && (both_q || fsel_q);

endmodule : cal_sequencer
`default_nettype wire

// ===== synth_cal_pa_config_regs.sv
// register group: loop gain, synthesizer calibration, amplifier level,
// matching capacitors and I/Q phase trim
// assumes a plain byte register port, read data one cycle after the strobe,
// and a reference tick synchronous to CLK
//
// Summary of operation
// - 8-bit loop gain factor, reset 134
// - trigger rising edge starts calibration
// - dual-store writes results to A and B
// - otherwise store to setting chosen by select
// - duration code picks 90k-200k reference periods
// - DAC seed field gives start value plus one
// - upper amplifier nibble drives strong array
// - lower amplifier nibble drives weak array, reset 15
// - upper matching nibble selects receive caps
// - lower matching nibble selects transmit caps
// - phase trim is signed two's complement
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module synth_cal_pa_config_regs #(
    parameter int CAL_WAIT0 = cfg_pkg::CAL_WAIT_0,
    parameter int CAL_WAIT1 = cfg_pkg::CAL_WAIT_1,
    parameter int CAL_WAIT2 = cfg_pkg::CAL_WAIT_2,
    parameter int CAL_WAIT3 = cfg_pkg::CAL_WAIT_3
) (
    // clock and reset
    input  wire logic              CLK,
    input  wire logic              RST_B,
    // register port
    input  wire logic [7:0]        ADDR,
    input  wire logic [7:0]        WDATA,
    input  wire logic              WR,
    input  wire logic              RD,
    output logic      [7:0]        RDATA,
    // synthesizer side
    input  wire logic              REF_TICK,        // one pulse per reference period
    input  wire logic              FREQ_SEL,        // frequency set select, 0 A, 1 B
    output logic      [7:0]        LOOP_GAIN,
    output logic                   CAL_BUSY,
    output logic                   CAL_STORE_A,
    output logic                   CAL_STORE_B,
    output logic      [3:0]        CAL_DAC_START,   // 1 to 8
    // amplifier and matching
    output logic      [3:0]        PA_STRONG_LEVEL,
    output logic      [3:0]        PA_WEAK_LEVEL,
    output logic      [3:0]        RX_MATCH_SEL,
    output logic      [3:0]        TX_MATCH_SEL,
    // phase trim
    output logic signed [7:0]      PHASE_TRIM
);

    ////////////////////////////////////////////////////////////////////////
    // storage
    logic [7:0] loop_gain_q;     // charge-pump scaling
    logic [7:0] cal_ctrl_q;      // trigger, dual, wait, seed
    logic [7:0] amp_level_q;     // strong and weak nibbles
    logic [7:0] match_q;         // rx and tx caps
    logic [7:0] phase_q;         // signed trim
    logic [7:0] rdata_q;         // read data, one cycle late
    logic       trig_prev_q;     // trigger value last cycle
    logic       cal_start;       // rising edge of trigger
    logic       cal_busy;        // sequencer running

    // write decode helper
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    ////////////////////////////////////////////////////////////////////////
    // plain configuration registers
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            loop_gain_q <= cfg_pkg::RST_LOOP_GAIN;
            amp_level_q <= cfg_pkg::RST_AMP_LEVEL;
            match_q     <= cfg_pkg::RST_MATCH_CAPS;
            phase_q     <= cfg_pkg::RST_PHASE_TRIM;
        end else if (WR) begin
            if (hit(ADDR, cfg_pkg::OFS_LOOP_GAIN)) begin
                loop_gain_q <= WDATA;
            end
            if (hit(ADDR, cfg_pkg::OFS_AMP_LEVEL)) begin
                amp_level_q <= WDATA;
            end
            if (hit(ADDR, cfg_pkg::OFS_MATCH_CAPS)) begin
                match_q <= WDATA;
            end
            if (hit(ADDR, cfg_pkg::OFS_PHASE_TRIM)) begin
                phase_q <= WDATA;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // calibration control; the trigger falls back to 0 when the run ends,
    // but a write in the same cycle wins so software is never overridden
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            cal_ctrl_q <= cfg_pkg::RST_CAL_CTRL;
        end else if (WR && hit(ADDR, cfg_pkg::OFS_CAL_CTRL)) begin
            cal_ctrl_q <= WDATA & cfg_pkg::CAL_CTRL_MASK;
        end else if (CAL_STORE_A || CAL_STORE_B) begin
            cal_ctrl_q[cfg_pkg::CAL_TRIG_BIT] <= 1'b0;
        end
    end

    // edge detect on the trigger bit
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            trig_prev_q <= 1'b0;
        end else begin
            trig_prev_q <= cal_ctrl_q[cfg_pkg::CAL_TRIG_BIT];
        end
    end

    // only a 0 to 1 transition starts a run; holding 1 does nothing more
    assign cal_start = cal_ctrl_q[cfg_pkg::CAL_TRIG_BIT] && !trig_prev_q && !cal_busy;

    ////////////////////////////////////////////////////////////////////////
    // sequencer
    cal_sequencer #(
        .WAIT0      (CAL_WAIT0),
        .WAIT1      (CAL_WAIT1),
        .WAIT2      (CAL_WAIT2),
        .WAIT3      (CAL_WAIT3)
    ) u_seq (
        .clk        (CLK),
        .rst_b      (RST_B),
        .start      (cal_start),
        .ref_tick   (REF_TICK),
        .wait_sel   (cal_ctrl_q[cfg_pkg::CAL_WAIT_HI:cfg_pkg::CAL_WAIT_LO]),
        .store_both (cal_ctrl_q[cfg_pkg::CAL_BOTH_BIT]),
        .freq_sel   (FREQ_SEL),
        .busy       (cal_busy),
        .store_a    (CAL_STORE_A),
        .store_b    (CAL_STORE_B)
    );

    ////////////////////////////////////////////////////////////////////////
    // read port; unmapped addresses read zero
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            rdata_q <= 8'h00;
        end else if (RD) begin
            unique case (ADDR)
                cfg_pkg::OFS_LOOP_GAIN:  rdata_q <= loop_gain_q;
                cfg_pkg::OFS_CAL_CTRL:   rdata_q <= cal_ctrl_q;
                cfg_pkg::OFS_AMP_LEVEL:  rdata_q <= amp_level_q;
                cfg_pkg::OFS_MATCH_CAPS: rdata_q <= match_q;
                cfg_pkg::OFS_PHASE_TRIM: rdata_q <= phase_q;
                cfg_pkg::OFS_CAL_STATUS: rdata_q <= {7'h00, cal_busy};
                default:                 rdata_q <= 8'h00;
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign RDATA           = rdata_q;
    assign LOOP_GAIN       = loop_gain_q;
    assign CAL_BUSY        = cal_busy;
    // seed code plus one gives start value 1..8
    assign CAL_DAC_START   = {1'b0, cal_ctrl_q[cfg_pkg::CAL_SEED_HI:cfg_pkg::CAL_SEED_LO]}
                             + 4'h1;
    assign PA_STRONG_LEVEL = amp_level_q[7:4];
    assign PA_WEAK_LEVEL   = amp_level_q[3:0];
    assign RX_MATCH_SEL    = match_q[7:4];
    assign TX_MATCH_SEL    = match_q[3:0];
    assign PHASE_TRIM      = $signed(phase_q);

endmodule : synth_cal_pa_config_regs
`default_nettype wire

// ===== synth_cal_pa_config_regs_sva.sv
// checker for the loop gain, calibration, amplifier, matching and trim registers
// assumes it is bound to the register group and sees only its ports
`timescale 1ns/10ps
`default_nettype none
module cfg_regs_checker #(
    parameter int CAL_WAIT0 = cfg_pkg::CAL_WAIT_0,
    parameter int CAL_WAIT3 = cfg_pkg::CAL_WAIT_3
) (
    // clock and reset
    input wire logic              CLK,
    input wire logic              RST_B,
    // register port
    input wire logic [7:0]        ADDR,
    input wire logic [7:0]        WDATA,
    input wire logic              WR,
    input wire logic              RD,
    input wire logic [7:0]        RDATA,
    // calibration
    input wire logic              REF_TICK,
    input wire logic              CAL_BUSY,
    input wire logic              CAL_STORE_A,
    input wire logic              CAL_STORE_B,
    input wire logic [3:0]        CAL_DAC_START,
    // register outputs
    input wire logic [7:0]        LOOP_GAIN,
    input wire logic [3:0]        PA_STRONG_LEVEL,
    input wire logic [3:0]        PA_WEAK_LEVEL,
    input wire logic [3:0]        RX_MATCH_SEL,
    input wire logic [3:0]        TX_MATCH_SEL,
    input wire logic signed [7:0] PHASE_TRIM
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);
    ////////////////////////////////////////////////////////////////////////////
    // ticks seen in the current run; wide enough for the full-length waits
    logic [17:0] ticks_q;
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            ticks_q <= 18'h00000;
        end else if (!CAL_BUSY) begin
            ticks_q <= 18'h00000; // idle clears the count
        end else if (REF_TICK) begin
            ticks_q <= ticks_q + 18'h00001;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    chk_gain_write: assert property (WR && ADDR == cfg_pkg::OFS_LOOP_GAIN
        |=> LOOP_GAIN == $past(WDATA)) else $error("loop gain not taken from write");
    chk_seed_plus: assert property (WR && ADDR == cfg_pkg::OFS_CAL_CTRL
        |=> CAL_DAC_START == {1'b0, $past(WDATA[2:0])} + 4'h1) else $error("dac start wrong");
    chk_amp_split: assert property (WR && ADDR == cfg_pkg::OFS_AMP_LEVEL
        |=> {PA_STRONG_LEVEL, PA_WEAK_LEVEL} == $past(WDATA)) else $error("amp nibbles wrong");
    chk_match_split: assert property (WR && ADDR == cfg_pkg::OFS_MATCH_CAPS
        |=> {RX_MATCH_SEL, TX_MATCH_SEL} == $past(WDATA)) else $error("match nibbles wrong");
    chk_trim_signed: assert property (WR && ADDR == cfg_pkg::OFS_PHASE_TRIM
        |=> PHASE_TRIM == $signed($past(WDATA))) else $error("phase trim wrong");
    chk_gain_readback: assert property (RD && ADDR == cfg_pkg::OFS_LOOP_GAIN
        |=> RDATA == LOOP_GAIN) else $error("loop gain read back wrong");
    chk_cal_start: assert property ($rose(CAL_BUSY) |-> $past(WR, 2) &&
        $past(ADDR, 2) == cfg_pkg::OFS_CAL_CTRL && $past(WDATA[7], 2)) else $error("bad start");
    chk_store_end: assert property ((CAL_STORE_A || CAL_STORE_B) |-> CAL_BUSY
        ##1 (!CAL_BUSY && !CAL_STORE_A && !CAL_STORE_B)) else $error("store not last cycle");
    chk_run_short: assert property ($fell(CAL_BUSY) |-> ticks_q >= CAL_WAIT0 - 1)
        else $error("calibration ended early");
    chk_run_bound: assert property (ticks_q <= CAL_WAIT3 + 1)
        else $error("calibration overran");
    // main scenarios
    cov_dual_store: cover property (CAL_STORE_A && CAL_STORE_B);
    cov_store_b: cover property (CAL_STORE_B && !CAL_STORE_A);
    cov_read: cover property (RD ##1 RDATA != 8'h00);
endmodule : cfg_regs_checker
`default_nettype wire

// ===== test_synth_cal_pa_config_regs.sv
// self-checking bench for the synthesizer, calibration and amplifier registers
// assumes shortened waits below and a reference tick on every second clock
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fails++; \
    $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end
module test_synth_cal_pa_config_regs;
    // waits step by one tick so runs differ by two clocks per code
    localparam int W0 = 3;
    localparam int W1 = 4;
    localparam int W2 = 5;
    localparam int W3 = 6;
    logic              clk, rst_b, wr, rd, ref_tick, freq_sel, cal_busy, store_a, store_b;
    logic [7:0]        addr, wdata, rdata, loop_gain;
    logic [3:0]        dac_start, pa_strong, pa_weak, rx_match, tx_match;
    logic signed [7:0] phase_trim;
    logic [7:0]        rst_tab [5] = '{8'h86, 8'h05, 8'h0F, 8'h00, 8'h00}; // reset image
    int                fails = 0;
    int                checked = 0;
    int                lens [4]; // busy cycles per wait code
    synth_cal_pa_config_regs #(.CAL_WAIT0(W0), .CAL_WAIT1(W1), .CAL_WAIT2(W2),
        .CAL_WAIT3(W3)) i_dut (
        .CLK(clk), .RST_B(rst_b), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
        .REF_TICK(ref_tick), .FREQ_SEL(freq_sel), .LOOP_GAIN(loop_gain), .CAL_BUSY(cal_busy),
        .CAL_STORE_A(store_a), .CAL_STORE_B(store_b), .CAL_DAC_START(dac_start),
        .PA_STRONG_LEVEL(pa_strong), .PA_WEAK_LEVEL(pa_weak), .RX_MATCH_SEL(rx_match),
        .TX_MATCH_SEL(tx_match), .PHASE_TRIM(phase_trim));
    ////////////////////////////////////////////////////////////////////////////
    // clock and reference tick
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) ref_tick <= ~ref_tick;
    ////////////////////////////////////////////////////////////////////////////
    // register port cycles; back-to-back strobes are separated by one idle cycle
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask : reg_write
    // read data stand only in the cycle after the strobe
    task automatic reg_check(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        `CHK(rdata, e)
    endtask : reg_check
    // one calibration; select flips mid-run since it must be latched at start
    task automatic run_cal(input logic [7:0] c, input logic fs, input logic [1:0] st,
                           output int n);
        int w = 0;
        logic [1:0] seen = 2'b00;
        n = 0;
        do @(posedge clk); while (ref_tick !== 1'b1); // same tick phase every run
        freq_sel <= fs;
        reg_write(cfg_pkg::OFS_CAL_CTRL, c);
        while (cal_busy !== 1'b1 && w < 8) begin
            @(posedge clk);
            #1;
            w++;
        end
        // status shows the run; select flips on an edge while still running
        reg_check(cfg_pkg::OFS_CAL_STATUS, 8'h01);
        @(posedge clk);
        freq_sel <= ~fs;
        #1;
        while (cal_busy === 1'b1 && n < 100) begin
            seen = seen | {store_a, store_b};
            @(posedge clk);
            #1;
            n++;
        end
        `CHK(seen, st)
        reg_check(cfg_pkg::OFS_CAL_CTRL, c & 8'h77);
        reg_check(cfg_pkg::OFS_CAL_STATUS, 8'h00);
    endtask : run_cal
    task automatic complete_run;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : complete_run
    ////////////////////////////////////////////////////////////////////////////
    // watchdog: the tests need well under a thousand cycles
    initial begin
        #100000;
        fails++;
        complete_run;
    end
    initial begin
        {rst_b, wr, rd, ref_tick, freq_sel} = 5'b00000;
        addr = 8'h00;
        wdata = 8'h00;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        #1;
        `CHK({loop_gain, dac_start}, 12'h866)
        `CHK({pa_strong, pa_weak, rx_match, tx_match, phase_trim}, 24'h0F0000)
        foreach (rst_tab[i]) reg_check(8'h1A + 8'(i), rst_tab[i]);
        reg_write(cfg_pkg::OFS_LOOP_GAIN, 8'hC3);
        reg_write(cfg_pkg::OFS_AMP_LEVEL, 8'hA0);
        reg_write(cfg_pkg::OFS_MATCH_CAPS, 8'h3C);
        reg_write(cfg_pkg::OFS_PHASE_TRIM, 8'h80);
        `CHK({loop_gain, pa_strong, pa_weak, rx_match, tx_match}, 24'hC3A03C)
        `CHK(phase_trim < 0, 1'b1)
        reg_write(8'h40, 8'hFF); // unmapped write is dropped
        reg_check(8'h40, 8'h00);
        reg_check(cfg_pkg::OFS_LOOP_GAIN, 8'hC3);
        reg_check(cfg_pkg::OFS_AMP_LEVEL, 8'hA0);
        reg_check(cfg_pkg::OFS_MATCH_CAPS, 8'h3C);
        reg_check(cfg_pkg::OFS_PHASE_TRIM, 8'h80);
        // every seed code, reserved bit written high
        for (int k = 0; k < 8; k++) begin
            reg_write(cfg_pkg::OFS_CAL_CTRL, {5'b00001, k[2:0]});
            `CHK(dac_start, 4'(k + 1))
            reg_check(cfg_pkg::OFS_CAL_CTRL, {5'b00000, k[2:0]});
        end
        // every wait code with dual store
        for (int k = 0; k < 4; k++) begin
            run_cal({2'b11, k[1:0], 4'h4}, 1'b0, 2'b11, lens[k]);
        end
        for (int k = 1; k < 4; k++) begin
            `CHK(lens[k] - lens[0], 2 * k)
        end
        run_cal(8'hB4, 1'b0, 2'b10, lens[0]);
        run_cal(8'hB4, 1'b1, 2'b01, lens[0]);
        complete_run;
    end
endmodule : test_synth_cal_pa_config_regs
bind synth_cal_pa_config_regs cfg_regs_checker #(.CAL_WAIT0(CAL_WAIT0), .CAL_WAIT3(CAL_WAIT3))
    i_chk (.CLK(CLK), .RST_B(RST_B), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .REF_TICK(REF_TICK), .CAL_BUSY(CAL_BUSY), .CAL_STORE_A(CAL_STORE_A),
    .CAL_STORE_B(CAL_STORE_B), .CAL_DAC_START(CAL_DAC_START), .LOOP_GAIN(LOOP_GAIN),
    .PA_STRONG_LEVEL(PA_STRONG_LEVEL), .PA_WEAK_LEVEL(PA_WEAK_LEVEL),
    .RX_MATCH_SEL(RX_MATCH_SEL), .TX_MATCH_SEL(TX_MATCH_SEL), .PHASE_TRIM(PHASE_TRIM));
`default_nettype wire
